// File: core/dimctl_pkg.sv
package dimctl_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int REG_W = 8;
  localparam logic [7:0] OFS_LEVEL = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h01;
  localparam logic [7:0] OFS_STATUS = 8'h02;
  localparam logic [7:0] LEVEL_RST = 8'hFF;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;
  localparam logic [7:0] LEVEL_MAX = 8'hFF;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_SRC_BIT = 1;
  localparam int CTRL_INTERP_BIT = 2;
  localparam int ST_FAULT_BIT = 0;
  localparam int ST_THERM_BIT = 1;
  localparam int ST_OVC_BIT = 2;
  localparam int ST_ON_BIT = 3;
  localparam int ST_ONE_BIT = 4;
  localparam int ST_TWO_BIT = 5;

  // ----------------------------------------------------------------
  // Serial port and device
  // ----------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR = 7'h2C;
  localparam int NUM_CH = 6;
  localparam int SYNC_W = NUM_CH + 5;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_HZ = 100_000_000;
  localparam int ON_DELAY_US = 4000;
  localparam int ON_DELAY_CYCLES = ON_DELAY_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int PWM_PRESCALE = 16;
  localparam int METER_DIV = 1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    BUS_IDLE = 4'b0000,
    BUS_ADDR = 4'b0001,
    BUS_ACK_A = 4'b0010,
    BUS_REG = 4'b0011,
    BUS_ACK_R = 4'b0100,
    BUS_WDAT = 4'b0101,
    BUS_ACK_W = 4'b0110,
    BUS_RDAT = 4'b0111,
    BUS_ACK_M = 4'b1000
  } bus_state_t;

  typedef enum logic [1:0] {
    DIM_OFF = 2'b00,
    DIM_EXT = 2'b01,
    DIM_HOST = 2'b10,
    DIM_SCALED = 2'b11
  } dim_mode_t;

endpackage

// File: core/duty_meter.sv
module duty_meter
  import dimctl_pkg::*;
#(
  parameter int DIV = METER_DIV
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Synchronised external dimming level
  input wire logic level_i,
  // Measured duty, 0..255
  output logic [7:0] duty_o
);

  // ----------------------------------------------------------------
  // Window of 255 samples, so the high count is the duty code
  // ----------------------------------------------------------------
  // Window must span many input periods or the reading jitters.
  localparam int DIV_W = (DIV > 1) ? $clog2(DIV) : 1;

  logic [DIV_W-1:0] div_cnt;
  logic [7:0] sample_cnt;
  logic [7:0] high_cnt;
  logic tick;

  assign tick = (div_cnt == DIV_W'(DIV - 1));

  always_ff @(posedge mclk_i) begin
    if (rst_i || tick) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sample_cnt <= '0;
      high_cnt <= '0;
      duty_o <= '0;
    end else if (tick) begin
      if (sample_cnt == LEVEL_MAX - 8'h01) begin
        sample_cnt <= '0;
        high_cnt <= '0;
        duty_o <= high_cnt + {7'h00, level_i};
      end else begin
        sample_cnt <= sample_cnt + 8'h01;
        high_cnt <= high_cnt + {7'h00, level_i};
      end
    end
  end

endmodule // duty_meter

// File: core/dim_pwm_gen.sv
module dim_pwm_gen
  import dimctl_pkg::*;
#(
  parameter int PRESCALE = PWM_PRESCALE
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Duty code
  input wire logic [7:0] code_i,
  // Dimming waveform
  output logic pwm_o
);

  // ----------------------------------------------------------------
  // Period of 255 slots: code N is high for N slots
  // ----------------------------------------------------------------
  localparam int PRE_W = (PRESCALE > 1) ? $clog2(PRESCALE) : 1;

  logic [PRE_W-1:0] pre_cnt;
  logic [7:0] slot;
  logic step;

  assign step = (pre_cnt == PRE_W'(PRESCALE - 1));

  always_ff @(posedge mclk_i) begin
    if (rst_i || step) begin
      pre_cnt <= '0;
    end else begin
      pre_cnt <= pre_cnt + 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      slot <= '0;
    end else if (step) begin
      slot <= (slot == LEVEL_MAX - 8'h01) ? 8'h00 : slot + 8'h01;
    end
  end

  // Zero never goes high, 255 never goes low
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pwm_o <= 1'b0;
    end else begin
      pwm_o <= (slot < code_i);
    end
  end

endmodule // dim_pwm_gen

// File: core/backlight_dimming_control_regs.sv
// Contract
// - Codes 1..255 give linear duty, 0.39% steps
// - Code zero drives no LED current
// - Level write accepted only in host source
// - Level read returns programmed code
// - 0xFF maximum brightness, 0x00 minimum
// - Level register resets to all ones
// - Reserved control bits inert, read as written
// - Control read returns all eight latched bits
// - Enable on within 4 ms of write
// - Enable cleared turns backlight off at once
// - Mode decode from enable, source, interpretation
// - Scaled mode: level times external duty
// - Scaled mode leaves level register untouched
// - Control resets to zero, backlight off
// - Summary fault is OR of four faults
// - Status read-only except clearable bit 0
// - Status bit 3 shows backlight on
// - Channel shutdown bits for one, two failures
// - Brief on then off reports no fault
// - Summary fault sticky, cleared by toggle/write
// - Status resets to zero
// - Byte registers over serial read/write byte
// - Channel readout zero for disabled or faulted
module backlight_dimming_control_regs
  import dimctl_pkg::*;
#(
  parameter int ON_DELAY = ON_DELAY_CYCLES
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Serial host port, open drain data
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // External dimming input
  input wire logic external_dimming_input_i,
  // Protection indications
  input wire logic thermal_trip_flag_i,
  input wire logic input_overcurrent_flag_i,
  input wire logic [NUM_CH-1:0] channel_fault_i,
  // Channel enables from the channel register
  input wire logic [NUM_CH-1:0] channel_enable_i,
  // Backlight outputs
  output logic dim_pwm_o,
  output logic [NUM_CH-1:0] channel_gate_o,
  output logic backlight_on_status_o
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int DLY_W = $clog2(ON_DELAY + 1);
  // Only the two bus pins idle high
  localparam int IDLE_HIGH_W = 2;

  logic [SYNC_W-1:0] async_in;
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;

  assign async_in = {channel_fault_i, input_overcurrent_flag_i,
                     thermal_trip_flag_i, external_dimming_input_i,
                     sda_i, scl_i};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_ff @(posedge mclk_i) begin
        if (rst_i) begin
          // Fault stages reset low, or reset itself sets the sticky fault
          sync_a[gi] <= 1'(gi < IDLE_HIGH_W);
          sync_b[gi] <= 1'(gi < IDLE_HIGH_W);
        end else begin
          sync_a[gi] <= async_in[gi];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate

  logic scl_s, sda_s, ext_s, therm_s, ovc_s;
  logic [NUM_CH-1:0] chf_s;
  logic scl_d, sda_d;

  assign scl_s = sync_b[0];
  assign sda_s = sync_b[1];
  assign ext_s = sync_b[2];
  assign therm_s = sync_b[3];
  assign ovc_s = sync_b[4];
  assign chf_s = sync_b[SYNC_W-1:5];

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;

  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  // Sampled copies keep a data edge from racing the clock edge
  assign bus_start = scl_s && scl_d && sda_d && !sda_s;
  assign bus_stop = scl_s && scl_d && !sda_d && sda_s;

  // ----------------------------------------------------------------
  // Serial byte slave
  // ----------------------------------------------------------------
  bus_state_t state;
  logic [2:0] bit_cnt;
  logic [7:0] shift_in;
  logic [7:0] tx_byte;
  logic [7:0] ptr;
  logic [7:0] rd_data;
  logic [7:0] rx_byte;
  logic wr_pulse;
  logic [7:0] wr_data;

  assign rx_byte = {shift_in[6:0], sda_s};

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state <= BUS_IDLE;
      bit_cnt <= '0;
      shift_in <= '0;
      tx_byte <= '0;
      ptr <= '0;
      wr_pulse <= 1'b0;
      wr_data <= '0;
    end else begin
      wr_pulse <= 1'b0;
      if (bus_start) begin
        state <= BUS_ADDR;
        bit_cnt <= '0;
      end else if (bus_stop) begin
        state <= BUS_IDLE;
      end else if (scl_rise) begin
        case (state)
          BUS_ADDR, BUS_REG, BUS_WDAT: begin
            shift_in <= rx_byte;
            bit_cnt <= bit_cnt + 3'd1;
            if (bit_cnt == 3'd7) begin
              if (state == BUS_ADDR) begin
                state <= (rx_byte[7:1] == SLAVE_ADDR) ? BUS_ACK_A : BUS_IDLE;
              end else if (state == BUS_REG) begin
                ptr <= rx_byte;
                state <= BUS_ACK_R;
              end else begin
                wr_data <= rx_byte;
                wr_pulse <= 1'b1;
                state <= BUS_ACK_W;
              end
            end
          end
          BUS_ACK_A: begin
            bit_cnt <= '0;
            if (shift_in[0]) begin
              tx_byte <= rd_data;
              state <= BUS_RDAT;
            end else begin
              state <= BUS_REG;
            end
          end
          BUS_ACK_R: begin
            bit_cnt <= '0;
            state <= BUS_WDAT;
          end
          BUS_ACK_W: begin
            bit_cnt <= '0;
            ptr <= ptr + 8'h01;
            state <= BUS_WDAT;
          end
          BUS_RDAT: begin
            tx_byte <= {tx_byte[6:0], 1'b0};
            bit_cnt <= bit_cnt + 3'd1;
            if (bit_cnt == 3'd7) begin
              state <= BUS_ACK_M;
            end
          end
          BUS_ACK_M: begin
            bit_cnt <= '0;
            if (sda_s) begin
              state <= BUS_IDLE;
            end else begin
              tx_byte <= rd_data;
              state <= BUS_RDAT;
            end
          end
          default: begin
            state <= BUS_IDLE;
          end
        endcase
      end
    end
  end

  // Burst reads re-read the same pointer; writes walk upward
  // Data line changes only while the clock is low
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sda_oe_o <= 1'b0;
    end else if (bus_start || bus_stop) begin
      sda_oe_o <= 1'b0;
    end else if (scl_fall) begin
      case (state)
        BUS_ACK_A, BUS_ACK_R, BUS_ACK_W: sda_oe_o <= 1'b1;
        BUS_RDAT: sda_oe_o <= !tx_byte[7];
        default: sda_oe_o <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    sda_o <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] level;
  logic [7:0] ctrl;
  logic fault;
  logic bl_on;
  logic one_sd, two_sd;
  dim_mode_t mode;

  always_comb begin
    if (!ctrl[CTRL_EN_BIT]) begin
      mode = DIM_OFF;
    end else if (ctrl[CTRL_SRC_BIT]) begin
      mode = DIM_EXT;
    end else if (ctrl[CTRL_INTERP_BIT]) begin
      mode = DIM_HOST;
    end else begin
      mode = DIM_SCALED;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      level <= LEVEL_RST;
    end else if (wr_pulse && ptr == OFS_LEVEL
                 && !ctrl[CTRL_SRC_BIT]) begin
      level <= wr_data;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ctrl <= CTRL_RST;
    end else if (wr_pulse && ptr == OFS_CTRL) begin
      ctrl <= wr_data;
    end
  end

  // Enable edge from a control write, used only for the fault clear
  logic en_toggle;
  assign en_toggle = wr_pulse && ptr == OFS_CTRL
                     && (wr_data[CTRL_EN_BIT] != ctrl[CTRL_EN_BIT]);

  logic [DLY_W-1:0] on_cnt;

  always_ff @(posedge mclk_i) begin
    if (rst_i || !ctrl[CTRL_EN_BIT]) begin
      on_cnt <= '0;
      bl_on <= 1'b0;
    end else if (!bl_on) begin
      if (on_cnt == DLY_W'(ON_DELAY - 1)) begin
        bl_on <= 1'b1;
      end else begin
        on_cnt <= on_cnt + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status and faults
  // ----------------------------------------------------------------
  function automatic logic [3:0] count_ones(input logic [NUM_CH-1:0] v);
    logic [3:0] n;
    n = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      n = n + {3'b000, v[i]};
    end
    return n;
  endfunction

  logic [3:0] n_failed;
  // Strings only count as failed while lit, so a brief on/off is quiet
  assign n_failed = count_ones(chf_s & channel_enable_i
                               & {NUM_CH{bl_on}});

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      one_sd <= 1'b0;
      two_sd <= 1'b0;
    end else begin
      one_sd <= (n_failed >= 4'd1);
      two_sd <= (n_failed >= 4'd2);
    end
  end

  logic fault_cause, fault_clear;
  assign fault_cause = therm_s || ovc_s || one_sd || two_sd;
  assign fault_clear = en_toggle || (wr_pulse && ptr == OFS_STATUS
                       && !wr_data[ST_FAULT_BIT]);

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      fault <= 1'b0;
    end else if (fault_cause) begin
      fault <= 1'b1;
    end else if (fault_clear) begin
      fault <= 1'b0;
    end
  end

  always_comb begin
    rd_data = UNMAPPED_RD;
    case (ptr)
      OFS_LEVEL: rd_data = level;
      OFS_CTRL: rd_data = ctrl;
      OFS_STATUS: begin
        rd_data = STATUS_RST;
        rd_data[ST_FAULT_BIT] = fault;
        rd_data[ST_THERM_BIT] = therm_s;
        rd_data[ST_OVC_BIT] = ovc_s;
        rd_data[ST_ON_BIT] = bl_on;
        rd_data[ST_ONE_BIT] = one_sd;
        rd_data[ST_TWO_BIT] = two_sd;
      end
      default: rd_data = UNMAPPED_RD;
    endcase
  end

  // ----------------------------------------------------------------
  // Dimming path
  // ----------------------------------------------------------------
  logic [7:0] ext_duty;
  logic [15:0] product;
  logic [7:0] code;
  logic gen_pwm;

  duty_meter u_meter (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .level_i(ext_s),
    .duty_o(ext_duty)
  );

  // Rounding terms make 255 x 255 come out as full scale
  assign product = level * ext_duty + {8'h00, level}
                   + {8'h00, ext_duty};
  assign code = (mode == DIM_SCALED) ? product[15:8] : level;

  dim_pwm_gen u_gen (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .code_i(code),
    .pwm_o(gen_pwm)
  );

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      dim_pwm_o <= 1'b0;
      channel_gate_o <= '0;
      backlight_on_status_o <= 1'b0;
    end else begin
      // Code zero keeps the strings dark; 0xFF keeps them lit
      dim_pwm_o <= bl_on && ((mode == DIM_EXT) ? ext_s : gen_pwm);
      channel_gate_o <= bl_on ? (channel_enable_i & ~chf_s)
                              : '0;
      backlight_on_status_o <= bl_on;
    end
  end

endmodule // backlight_dimming_control_regs

// File: bench/dimctl_asserts.sv
module dimctl_asserts
  import dimctl_pkg::*;
(
  // Clock, reset, serial pins
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  // Strings and outputs
  input wire logic [NUM_CH-1:0] channel_fault_i,
  input wire logic [NUM_CH-1:0] channel_enable_i,
  input wire logic dim_pwm_o,
  input wire logic [NUM_CH-1:0] channel_gate_o,
  input wire logic backlight_on_status_o
);
  // ----------------------------------------
  // Port checks
  // ----------------------------------------
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  pin_pull_only_a: assert property (
    sda_oe_o |-> !sda_o) else $error("data pin driven high");
  // Moving data under a high clock would fake a start or stop
  steady_high_a: assert property (
    scl_i [*3] |-> $stable(sda_oe_o)) else $error("data moved, clock high");
  gate_needs_on_a: assert property (
    channel_gate_o != '0 |-> backlight_on_status_o
      || $past(backlight_on_status_o, 2)) else $error("gate while off");
  gate_masked_a: assert property (
    (channel_gate_o & ~$past(channel_enable_i)) == '0)
    else $error("gate on disabled string");
  on_all_gates_a: assert property (
    (backlight_on_status_o && channel_fault_i == '0) [*6]
      |-> channel_gate_o == $past(channel_enable_i))
    else $error("gate differs from enables");
  reset_dark_a: assert property (
    $fell(rst_i) |-> !backlight_on_status_o && channel_gate_o == '0)
    else $error("lit after reset");
  off_dark_a: assert property (
    $fell(backlight_on_status_o) |-> ##[0:3]
      (!dim_pwm_o && channel_gate_o == '0)) else $error("still lit");
  fault_drops_a: assert property (
    channel_fault_i[0] [*4] |=> !channel_gate_o[0])
    else $error("faulted string gated");
endmodule // dimctl_asserts

bind backlight_dimming_control_regs dimctl_asserts dimctl_asserts_inst (
  .mclk_i(mclk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .channel_fault_i(channel_fault_i),
  .channel_enable_i(channel_enable_i), .dim_pwm_o(dim_pwm_o),
  .channel_gate_o(channel_gate_o),
  .backlight_on_status_o(backlight_on_status_o));

// File: bench/host_model.sv
module host_model
  import dimctl_pkg::*;
(
  // Clock and data line
  input wire logic clk_i,
  input wire logic sda_i,
  // Serial pins, release means pull-up
  output logic scl_o,
  output logic sda_rel_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Bus cycles, 8 clocks a bit
  // ----------------------------------------
  initial begin
    scl_o = 1'b1;
    sda_rel_o = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Extra low time so the slave's ack release settles first
  task automatic start();
    tick(4);
    sda_rel_o <= 1'b1;
    tick(2);
    scl_o <= 1'b1;
    tick(4);
    sda_rel_o <= 1'b0;
    tick(4);
    scl_o <= 1'b0;
  endtask

  task automatic stop();
    tick(2);
    sda_rel_o <= 1'b0;
    tick(4);
    scl_o <= 1'b1;
    tick(4);
    sda_rel_o <= 1'b1;
    tick(4);
  endtask

  task automatic bits9(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      tick(2);
      sda_rel_o <= tx[i];
      tick(2);
      scl_o <= 1'b1;
      tick(2);
      rx[i] = sda_i;
      tick(2);
      scl_o <= 1'b0;
    end
  endtask

  task automatic write_reg(input logic [6:0] adr, input logic [7:0] ofs, d,
                           output logic ok);
    logic [8:0] r0, r1, r2;
    start();
    bits9({adr, 2'b01}, r0);
    bits9({ofs, 1'b1}, r1);
    bits9({d, 1'b1}, r2);
    stop();
    ok = !(r0[0] | r1[0] | r2[0]);
  endtask

  task automatic read_reg(input logic [7:0] ofs, output logic [7:0] d);
    logic [8:0] r;
    start();
    bits9({SLAVE_ADDR, 2'b01}, r);
    bits9({ofs, 1'b1}, r);
    start();
    bits9({SLAVE_ADDR, 2'b11}, r);
    bits9(9'h1FF, r);
    stop();
    d = r[8:1];
  endtask
endmodule // host_model

// File: bench/backlight_dimming_control_regs_tb.sv
module backlight_dimming_control_regs_tb
  import dimctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int ON_D = 300;
  localparam int PER = 255 * PWM_PRESCALE;
  logic mclk_i, rst_i, scl, sda_rel, sda_o, sda_oe, ext_in, therm, ovc;
  logic pwm, on, ok;
  logic [NUM_CH-1:0] ch_fault, ch_en, gate;
  wire logic sda_line = sda_rel & (~sda_oe | sda_o);
  integer seed = 32'h0555;
  int err_count = 0;
  int n_checks = 0;
  int cycles = 0;

  backlight_dimming_control_regs #(.ON_DELAY(ON_D))
    backlight_dimming_control_regs_inst (
    .mclk_i(mclk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe_o(sda_oe),
    .external_dimming_input_i(ext_in), .thermal_trip_flag_i(therm),
    .input_overcurrent_flag_i(ovc), .channel_fault_i(ch_fault),
    .channel_enable_i(ch_en), .dim_pwm_o(pwm), .channel_gate_o(gate),
    .backlight_on_status_o(on));
  host_model host_model_inst (.clk_i(mclk_i), .sda_i(sda_line),
    .scl_o(scl), .sda_rel_o(sda_rel));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 98000) begin
      err_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (err_count == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] ofs, d);
    logic a;
    host_model_inst.write_reg(SLAVE_ADDR, ofs, d, a);
    check("ack", 16'(a), 16'h0001);
  endtask

  task automatic rd_chk(input string name, input logic [7:0] ofs, exp);
    logic [7:0] d;
    host_model_inst.read_reg(ofs, d);
    check(name, 16'(d), 16'(exp));
  endtask

  // One period to settle, one to count; any whole period is exact
  task automatic pwm_chk(input logic [15:0] exp);
    logic [15:0] n;
    n = 16'h0000;
    repeat (PER) @(posedge mclk_i);
    repeat (PER) begin
      @(posedge mclk_i);
      n += 16'(pwm);
    end
    check("pwm high count", n, exp);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] c, d, lvl;
    logic [7:0] codes [4];
    rst_i = 1'b1;
    ext_in = 1'b0;
    therm = 1'b0;
    ovc = 1'b0;
    ch_fault = '0;
    ch_en = NUM_CH'($random(seed)) | NUM_CH'(3);
    codes = '{8'h00, 8'h01, 8'hFF, 8'h00};
    codes[3] = 8'($random(seed));
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    rd_chk("level", OFS_LEVEL, LEVEL_RST);
    rd_chk("ctrl", OFS_CTRL, CTRL_RST);
    rd_chk("status", OFS_STATUS, STATUS_RST);
    rd_chk("unmapped", 8'h05, UNMAPPED_RD);
    lvl = LEVEL_RST;
    for (int i = 0; i < 6; i++) begin
      c = (8'($random(seed)) & 8'hFC) | 8'(i % 2 * 2);
      d = 8'($random(seed));
      wr(OFS_CTRL, c);
      rd_chk("ctrl", OFS_CTRL, c);
      wr(OFS_LEVEL, d);
      if (!c[CTRL_SRC_BIT])
        lvl = d;
      rd_chk("level", OFS_LEVEL, lvl);
    end
    host_model_inst.write_reg(SLAVE_ADDR ^ 7'h01, OFS_CTRL, 8'h05, ok);
    check("foreign ack", 16'(ok), 16'h0000);
    rd_chk("ctrl", OFS_CTRL, c);
    wr(OFS_CTRL, 8'h05);
    for (int k = 0; k < ON_D + 20 && on !== 1'b1; k++)
      @(posedge mclk_i);
    repeat (2) @(posedge mclk_i);
    check("on", 16'(on), 16'h0001);
    check("gate", 16'(gate), 16'(ch_en));
    rd_chk("status", OFS_STATUS, 8'h08);
    foreach (codes[k]) begin
      wr(OFS_LEVEL, codes[k]);
      pwm_chk(16'(codes[k]) * 16'(PWM_PRESCALE));
    end
    wr(OFS_CTRL, 8'h01);
    ext_in <= 1'b1;
    pwm_chk(16'(codes[3]) * 16'(PWM_PRESCALE));
    ext_in <= 1'b0;
    pwm_chk(16'h0000);
    rd_chk("level", OFS_LEVEL, codes[3]);
    wr(OFS_CTRL, 8'h03);
    pwm_chk(16'h0000);
    wr(OFS_CTRL, 8'h07);
    ext_in <= 1'b1;
    pwm_chk(16'(PER));
    wr(OFS_CTRL, 8'h05);
    therm <= 1'b1;
    rd_chk("status", OFS_STATUS, 8'h0B);
    therm <= 1'b0;
    ovc <= 1'b1;
    rd_chk("status", OFS_STATUS, 8'h0D);
    ovc <= 1'b0;
    rd_chk("status", OFS_STATUS, 8'h09);
    wr(OFS_STATUS, 8'hFE);
    rd_chk("status", OFS_STATUS, 8'h08);
    ch_fault <= NUM_CH'(1);
    rd_chk("status", OFS_STATUS, 8'h19);
    check("gate", 16'(gate), 16'(ch_en & ~NUM_CH'(1)));
    ch_fault <= NUM_CH'(3);
    rd_chk("status", OFS_STATUS, 8'h39);
    wr(OFS_STATUS, 8'hFE);
    rd_chk("status", OFS_STATUS, 8'h39);
    ch_fault <= '0;
    wr(OFS_CTRL, 8'h04);
    check("off", 16'({on, gate}), 16'h0000);
    rd_chk("status", OFS_STATUS, 8'h00);
    ch_fault <= NUM_CH'(1);
    wr(OFS_CTRL, 8'h05);
    wr(OFS_CTRL, 8'h04);
    rd_chk("status", OFS_STATUS, 8'h00);
    ch_fault <= '0;
    rst_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    rd_chk("level", OFS_LEVEL, LEVEL_RST);
    report_and_stop();
  end
endmodule // backlight_dimming_control_regs_tb
